/* src/perf_counter_pkg.sv */
/*
 * Shared constants and carrier types of the E1 performance counter bank.
 * Assumes a host port that presents a page number and a 5-bit address.
 */
package perf_counter_pkg;

  localparam logic [7:0] PAGE_SEL        = 8'h04;
  localparam logic [4:0] OFS_PATTERN     = 5'h10;
  localparam logic [4:0] OFS_SUBMF       = 5'h11;
  localparam logic [4:0] OFS_VECTOR      = 5'h12;
  localparam logic [4:0] OFS_BLOCK_HI    = 5'h13;
  localparam logic [4:0] OFS_BLOCK_LO    = 5'h14;
  localparam logic [4:0] OFS_JFIFO       = 5'h15;
  localparam logic [4:0] OFS_OVERFLOW    = 5'h16;
  localparam logic [4:0] OFS_SYNC_LOSS   = 5'h17;
  localparam logic [4:0] OFS_BIT_ERR     = 5'h18;
  localparam logic [4:0] OFS_REMOTE_CRC  = 5'h19;
  localparam logic [4:0] OFS_ERR_ALIGN   = 5'h1A;
  localparam logic [4:0] OFS_ALARM       = 5'h1B;
  localparam logic [4:0] OFS_BPV_HI      = 5'h1C;
  localparam logic [4:0] OFS_BPV_LO      = 5'h1D;
  localparam logic [4:0] OFS_CRC_HI      = 5'h1E;
  localparam logic [4:0] OFS_CRC_LO      = 5'h1F;

  // Bit positions in the overflow latch
  localparam int OVF_PATTERN   = 7;
  localparam int OVF_BLOCK     = 6;
  localparam int OVF_JFIFO     = 5;
  localparam int OVF_SYNC_LOSS = 4;
  localparam int OVF_BIT_ERR   = 3;
  localparam int OVF_ERR_ALIGN = 2;
  localparam int OVF_BPV       = 1;
  localparam int OVF_CRC       = 0;

  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [9:0]  RST_10   = 10'h000;
  localparam logic [15:0] RST_16   = 16'h0000;

  typedef struct packed {
    logic       pattern_err;
    logic       submultiframe;
    logic       block_err;
    logic       fas_errored;
    logic [2:0] fas_bit_errs;
    logic       line_violation;
    logic       crc4_err;
  } count_evt_t;

  typedef struct packed {
    logic remote_alarm;
    logic all_ones;
    logic slot16_all_ones_event;
    logic signal_loss;
    logic auxiliary_pattern_event;
    logic multiframe_alarm_event;
    logic receive_slip_event;
  } alarm_evt_t;

endpackage

/* src/e1_performance_counter_bank.sv */
/*
 * Performance counter bank: error counters, overflow latch, alarm latch,
 * interrupt vector and jitter FIFO rate steering, read over the host port.
 * Assumes all event inputs and host strobes come from logic on i_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module e1_performance_counter_bank (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire logic [7:0]                  i_page,
  input  wire logic [4:0]                  i_addr,
  input  wire logic                        i_rd,
  input  wire logic                        i_wr,
  input  wire logic [7:0]                  i_wdata,
  output logic      [7:0]                  o_rdata,
  input  wire perf_counter_pkg::count_evt_t i_count_evt,
  input  wire perf_counter_pkg::alarm_evt_t i_alarm_evt,
  input  wire logic                        i_frame_tick,
  input  wire logic                        i_sync_lost,
  input  wire logic                        i_jfifo_near_under,
  input  wire logic                        i_jfifo_near_over,
  input  wire logic [7:0]                  i_int_vector,
  input  wire logic                        i_remote_crc_window,
  input  wire logic                        i_remote_crc_persist,
  output logic                             o_jfifo_read_slow,
  output logic                             o_jfifo_read_fast
);

  logic [7:0]  pattern_cnt, next_pattern_cnt;
  logic [7:0]  submf_cnt, next_submf_cnt;
  logic [9:0]  block_cnt, next_block_cnt;
  logic [7:0]  jfifo_cnt, next_jfifo_cnt;
  logic [7:0]  sync_cnt, next_sync_cnt;
  logic [7:0]  bit_err_cnt, next_bit_err_cnt;
  logic [7:0]  err_align_cnt, next_err_align_cnt;
  logic [15:0] bpv_cnt, next_bpv_cnt;
  logic [9:0]  crc_cnt, next_crc_cnt;
  logic [7:0]  ovf_latch, next_ovf_latch;
  logic [7:0]  alarm_latch, next_alarm_latch;
  logic        window_flag, next_window_flag;
  logic        near_q, next_near_q;
  logic        sync_q, next_sync_q;
  logic [7:0]  next_rdata;
  logic        next_read_slow, next_read_fast;
  logic [7:0]  ovf_set;
  logic [7:0]  alarm_set;
  logic        sel, rd_ovf, rd_alarm, rd_remote, wr_pat;
  logic        jfifo_inc, sync_enter, sync_inc;
  logic [8:0]  sum_pat, sum_wr, sum_jfifo, sum_sync, sum_bit, sum_align;
  logic [10:0] sum_block, sum_crc;
  logic [16:0] sum_bpv;

  always_comb begin
    sel        = (i_page == perf_counter_pkg::PAGE_SEL) && i_addr[4];
    wr_pat     = sel && i_wr && (i_addr == perf_counter_pkg::OFS_PATTERN);
    rd_ovf     = sel && i_rd && (i_addr == perf_counter_pkg::OFS_OVERFLOW);
    rd_alarm   = sel && i_rd && (i_addr == perf_counter_pkg::OFS_ALARM);
    rd_remote  = sel && i_rd && (i_addr == perf_counter_pkg::OFS_REMOTE_CRC);
    next_near_q = i_jfifo_near_under | i_jfifo_near_over;
    jfifo_inc  = next_near_q && !near_q;
    next_sync_q = i_sync_lost;
    sync_enter = i_sync_lost && !sync_q;
    sync_inc   = i_frame_tick && i_sync_lost;

    sum_pat   = {1'b0, pattern_cnt} + {8'h00, i_count_evt.pattern_err};
    sum_wr    = {1'b0, i_wdata} + {8'h00, i_count_evt.pattern_err};
    sum_block = {1'b0, block_cnt} + {10'h000, i_count_evt.block_err};
    sum_jfifo = {1'b0, jfifo_cnt} + {8'h00, jfifo_inc};
    sum_sync  = {1'b0, sync_cnt} + {8'h00, sync_inc};
    sum_bit   = {1'b0, bit_err_cnt} + {6'h00, i_count_evt.fas_bit_errs};
    sum_align = {1'b0, err_align_cnt} + {8'h00, i_count_evt.fas_errored};
    sum_bpv   = {1'b0, bpv_cnt} + {16'h0000, i_count_evt.line_violation};
    sum_crc   = {1'b0, crc_cnt} + {10'h000, i_count_evt.crc4_err};

    // Carry out of each sum is the overflow, except the sync sum on loss entry; the low part already wrapped
    ovf_set = '0;
    // A written value plus a coincident error can wrap as well
    ovf_set[perf_counter_pkg::OVF_PATTERN]   = wr_pat ? sum_wr[8] : sum_pat[8];
    ovf_set[perf_counter_pkg::OVF_BLOCK]     = sum_block[10];
    ovf_set[perf_counter_pkg::OVF_JFIFO]     = sum_jfifo[8];
    ovf_set[perf_counter_pkg::OVF_SYNC_LOSS] = sum_sync[8] && !sync_enter;
    ovf_set[perf_counter_pkg::OVF_BIT_ERR]   = sum_bit[8];
    ovf_set[perf_counter_pkg::OVF_ERR_ALIGN] = sum_align[8];
    ovf_set[perf_counter_pkg::OVF_BPV]       = sum_bpv[16];
    ovf_set[perf_counter_pkg::OVF_CRC]       = sum_crc[10];

    // Write value replaces the pattern count and clears the submultiframe count, a coincident event lands on top
    next_pattern_cnt = wr_pat ? sum_wr[7:0]
                              : sum_pat[7:0];
    next_submf_cnt   = wr_pat ? {7'h00, i_count_evt.submultiframe}
                              : submf_cnt + {7'h00, i_count_evt.submultiframe};
    next_block_cnt   = sum_block[9:0];
    next_jfifo_cnt   = sum_jfifo[7:0];
    next_sync_cnt    = sync_enter ? {7'h00, sync_inc} : sum_sync[7:0];
    next_bit_err_cnt = sum_bit[7:0];
    next_err_align_cnt = sum_align[7:0];
    next_bpv_cnt     = sum_bpv[15:0];
    next_crc_cnt     = sum_crc[9:0];

    // Set wins over the read clear
    next_ovf_latch = (rd_ovf ? perf_counter_pkg::RST_BYTE : ovf_latch) | ovf_set;
    alarm_set = {i_alarm_evt, 1'b0};
    next_alarm_latch = (rd_alarm ? perf_counter_pkg::RST_BYTE : alarm_latch) | alarm_set;
    next_window_flag = (window_flag && !rd_remote) || i_remote_crc_window;

    next_read_slow = i_jfifo_near_under;
    next_read_fast = i_jfifo_near_over;

    next_rdata = o_rdata;
    if (sel && i_rd) begin
      case (i_addr)
        perf_counter_pkg::OFS_PATTERN:    next_rdata = pattern_cnt;
        perf_counter_pkg::OFS_SUBMF:      next_rdata = submf_cnt;
        perf_counter_pkg::OFS_VECTOR:     next_rdata = i_int_vector;
        perf_counter_pkg::OFS_BLOCK_HI:   next_rdata = {6'h00, block_cnt[9:8]};
        perf_counter_pkg::OFS_BLOCK_LO:   next_rdata = block_cnt[7:0];
        perf_counter_pkg::OFS_JFIFO:      next_rdata = jfifo_cnt;
        perf_counter_pkg::OFS_OVERFLOW:   next_rdata = ovf_latch;
        perf_counter_pkg::OFS_SYNC_LOSS:  next_rdata = sync_cnt;
        perf_counter_pkg::OFS_BIT_ERR:    next_rdata = bit_err_cnt;
        perf_counter_pkg::OFS_REMOTE_CRC: next_rdata = {6'h00, window_flag, i_remote_crc_persist};
        perf_counter_pkg::OFS_ERR_ALIGN:  next_rdata = err_align_cnt;
        perf_counter_pkg::OFS_ALARM:      next_rdata = alarm_latch;
        perf_counter_pkg::OFS_BPV_HI:     next_rdata = bpv_cnt[15:8];
        perf_counter_pkg::OFS_BPV_LO:     next_rdata = bpv_cnt[7:0];
        perf_counter_pkg::OFS_CRC_HI:     next_rdata = {6'h00, crc_cnt[9:8]};
        perf_counter_pkg::OFS_CRC_LO:     next_rdata = crc_cnt[7:0];
        default:                          next_rdata = perf_counter_pkg::RST_BYTE;
      endcase
    end else if (i_rd) begin
      // Other pages and low addresses are served elsewhere
      next_rdata = perf_counter_pkg::RST_BYTE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pattern_cnt       <= perf_counter_pkg::RST_BYTE;
      submf_cnt         <= perf_counter_pkg::RST_BYTE;
      block_cnt         <= perf_counter_pkg::RST_10;
      jfifo_cnt         <= perf_counter_pkg::RST_BYTE;
      sync_cnt          <= perf_counter_pkg::RST_BYTE;
      bit_err_cnt       <= perf_counter_pkg::RST_BYTE;
      err_align_cnt     <= perf_counter_pkg::RST_BYTE;
      bpv_cnt           <= perf_counter_pkg::RST_16;
      crc_cnt           <= perf_counter_pkg::RST_10;
      ovf_latch         <= perf_counter_pkg::RST_BYTE;
      alarm_latch       <= perf_counter_pkg::RST_BYTE;
      window_flag       <= 1'b0;
      near_q            <= 1'b0;
      sync_q            <= 1'b0;
      o_rdata           <= perf_counter_pkg::RST_BYTE;
      o_jfifo_read_slow <= 1'b0;
      o_jfifo_read_fast <= 1'b0;
    end else begin
      pattern_cnt       <= next_pattern_cnt;
      submf_cnt         <= next_submf_cnt;
      block_cnt         <= next_block_cnt;
      jfifo_cnt         <= next_jfifo_cnt;
      sync_cnt          <= next_sync_cnt;
      bit_err_cnt       <= next_bit_err_cnt;
      err_align_cnt     <= next_err_align_cnt;
      bpv_cnt           <= next_bpv_cnt;
      crc_cnt           <= next_crc_cnt;
      ovf_latch         <= next_ovf_latch;
      alarm_latch       <= next_alarm_latch;
      window_flag       <= next_window_flag;
      near_q            <= next_near_q;
      sync_q            <= next_sync_q;
      o_rdata           <= next_rdata;
      o_jfifo_read_slow <= next_read_slow;
      o_jfifo_read_fast <= next_read_fast;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_pattern_count: assert property (
    i_count_evt.pattern_err && !wr_pat |=> pattern_cnt == $past(pattern_cnt) + 8'h01)
    else $error("pattern counter missed an error");

  a_submf_clear: assert property (
    wr_pat |=> submf_cnt == {7'h00, $past(i_count_evt.submultiframe)})
    else $error("submultiframe counter not cleared by write");

  a_vector_read: assert property (
    sel && i_rd && i_addr == perf_counter_pkg::OFS_VECTOR |=> o_rdata == $past(i_int_vector))
    else $error("interrupt vector read wrong");

  a_block_wrap: assert property (
    i_count_evt.block_err && block_cnt == 10'h3FF
      |=> block_cnt == 10'h000 && ovf_latch[perf_counter_pkg::OVF_BLOCK])
    else $error("block counter wrap or flag wrong");

  a_ovf_hold: assert property (
    ovf_latch[perf_counter_pkg::OVF_PATTERN] && !rd_ovf
      |=> ovf_latch[perf_counter_pkg::OVF_PATTERN])
    else $error("overflow flag dropped without read");

  a_ovf_clear: assert property (
    rd_ovf |=> ovf_latch == $past(ovf_set) && o_rdata == $past(ovf_latch))
    else $error("overflow read clear wrong");

  a_sync_clear: assert property (
    i_sync_lost && !sync_q |=> sync_cnt == {7'h00, $past(i_frame_tick)})
    else $error("sync loss counter not cleared on entry");

  a_jfifo_rate: assert property (
    i_jfifo_near_under |=> o_jfifo_read_slow)
    else $error("read clock not slowed near underflow");

  a_jfifo_count: assert property (
    $rose(i_jfifo_near_over) && !i_jfifo_near_under && !near_q && jfifo_cnt != 8'hFF
      |=> jfifo_cnt == $past(jfifo_cnt) + 8'h01)
    else $error("jitter counter missed an approach");

  a_bpv_count: assert property (
    i_count_evt.line_violation ##1 !i_count_evt.line_violation
      |=> bpv_cnt == $past(bpv_cnt, 2) + 16'h0001)
    else $error("violation counter missed a violation");

  a_alarm_latch: assert property (
    i_alarm_evt.receive_slip_event |=> alarm_latch[1])
    else $error("slip alarm not latched");

  a_alarm_clear: assert property (
    rd_alarm && i_alarm_evt == 7'h00 |=> alarm_latch == 8'h00)
    else $error("alarm latch not cleared by read");

  a_submf_count: assert property (
    i_count_evt.submultiframe && !wr_pat |=> submf_cnt == $past(submf_cnt) + 8'h01)
    else $error("submultiframe counter missed a count");

  a_pattern_write: assert property (
    wr_pat |=> pattern_cnt == $past(i_wdata) + {7'h00, $past(i_count_evt.pattern_err)})
    else $error("pattern counter write lost an error");

  a_pattern_flag: assert property (
    i_count_evt.pattern_err && pattern_cnt == 8'hFF && !wr_pat
      |=> pattern_cnt == 8'h00 && ovf_latch[perf_counter_pkg::OVF_PATTERN])
    else $error("pattern overflow not flagged");

  a_block_count: assert property (
    i_count_evt.block_err && block_cnt != 10'h3FF |=> block_cnt == $past(block_cnt) + 10'h001)
    else $error("block counter missed an error");

  a_jfifo_fast: assert property (
    i_jfifo_near_over |=> o_jfifo_read_fast)
    else $error("read clock not sped up near overflow");

  a_sync_count: assert property (
    i_frame_tick && i_sync_lost && sync_q && sync_cnt != 8'hFF
      |=> sync_cnt == $past(sync_cnt) + 8'h01)
    else $error("sync loss counter missed a frame");

  a_bpv_wrap: assert property (
    i_count_evt.line_violation && bpv_cnt == 16'hFFFF
      |=> bpv_cnt == 16'h0000 && ovf_latch[perf_counter_pkg::OVF_BPV])
    else $error("violation counter wrap or flag wrong");

  a_crc_count: assert property (
    i_count_evt.crc4_err && crc_cnt != 10'h3FF |=> crc_cnt == $past(crc_cnt) + 10'h001)
    else $error("crc counter missed an error");

  a_page_decode: assert property (
    i_rd && i_page != perf_counter_pkg::PAGE_SEL |=> o_rdata == 8'h00)
    else $error("foreign page read not zero");

  a_align_count: assert property (
    i_count_evt.fas_errored && err_align_cnt != 8'hFF
      |=> err_align_cnt == $past(err_align_cnt) + 8'h01)
    else $error("errored alignment counter missed a count");

  a_bit_err_sum: assert property (
    i_count_evt.fas_bit_errs != 3'h0
      |=> bit_err_cnt == $past(bit_err_cnt) + {5'h00, $past(i_count_evt.fas_bit_errs)})
    else $error("bit error counter sum wrong");

endmodule

`default_nettype wire

/* tb/host_model.sv */
/*
 Host processor model: single-cycle read and write strobes on the page port.
 Assumes its tasks are called just after a rising edge of i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic      [7:0] o_page,
  output logic      [4:0] o_addr,
  output logic            o_rd,
  output logic            o_wr,
  output logic      [7:0] o_wdata
);
  initial begin
    o_page  = 8'h00;
    o_addr  = 5'h00;
    o_rd    = 1'b0;
    o_wr    = 1'b0;
    o_wdata = 8'h00;
  end

  // Released lines show the inverse, so a stale value never passes
  task automatic release_bus();
    o_rd    = 1'b0;
    o_wr    = 1'b0;
    o_page  = ~o_page;
    o_addr  = ~o_addr;
    o_wdata = ~o_wdata;
  endtask

  task automatic rd(input logic [7:0] pg, input logic [4:0] a, output logic [7:0] d);
    o_page = pg;
    o_addr = a;
    o_rd   = 1'b1;
    @(posedge i_clk);
    #1;
    d = i_rdata;
    release_bus();
    @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    o_page  = 8'h04;
    o_addr  = a;
    o_wdata = v;
    o_wr    = 1'b1;
    @(posedge i_clk);
    #1;
    release_bus();
    @(posedge i_clk);
    #1;
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/*
 Self-checking bench for the performance counter bank.
 Assumes the host model drives the page port; events are driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                         i_clk = 1'b0;
  logic                         i_rst_n = 1'b0;
  logic [7:0]                   page, wdata, rdata, vec = 8'h3C;
  logic [4:0]                   addr;
  logic                         rd, wr, tick_f = 1'b0, lost = 1'b0;
  logic                         nunder = 1'b0, nover = 1'b0, win = 1'b0, pers = 1'b0;
  logic                         slow, fast;
  perf_counter_pkg::count_evt_t cevt = '0;
  perf_counter_pkg::alarm_evt_t aevt = '0;
  int                           n_fail = 0;
  int                           check_count = 0;

  always #50 i_clk = ~i_clk;

  e1_performance_counter_bank dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_page(page),
    .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wdata), .o_rdata(rdata),
    .i_count_evt(cevt), .i_alarm_evt(aevt), .i_frame_tick(tick_f), .i_sync_lost(lost),
    .i_jfifo_near_under(nunder), .i_jfifo_near_over(nover), .i_int_vector(vec),
    .i_remote_crc_window(win), .i_remote_crc_persist(pers),
    .o_jfifo_read_slow(slow), .o_jfifo_read_fast(fast));

  host_model host (.i_clk(i_clk), .i_rdata(rdata), .o_page(page), .o_addr(addr),
    .o_rd(rd), .o_wr(wr), .o_wdata(wdata));

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(8'h04, a, d);
    chk(d, e);
  endtask

  task automatic t_reset_map();
    logic [7:0] d;
    for (int a = 16; a < 32; a++) begin
      if (a == 18) rc(5'h12, 8'h3C);
      else rc(a[4:0], 8'h00);
    end
    rc(5'h12, 8'h3C);
    host.rd(8'h03, 5'h10, d);
    chk(d, 8'h00);
  endtask

  task automatic t_pattern_window();
    cevt.pattern_err = 1'b1;
    cevt.submultiframe = 1'b1;
    tick(3);
    cevt = '0;
    rc(5'h10, 8'h03);
    rc(5'h11, 8'h03);
    host.wr(5'h11, 8'h55);
    rc(5'h11, 8'h03);
    cevt.submultiframe = 1'b1;
    fork
      host.wr(5'h10, 8'hFE);
      begin tick(1); cevt = '0; end
    join
    rc(5'h11, 8'h01);
    cevt.pattern_err = 1'b1;
    tick(2);
    cevt = '0;
    rc(5'h10, 8'h00);
    rc(5'h16, 8'h80);
    rc(5'h16, 8'h00);
  endtask

  // One edge per count, so the 16-bit wrap costs 65537 cycles
  task automatic t_wide_counters();
    cevt = 9'b001111111;
    cevt.fas_bit_errs = 3'd1;
    tick(257);
    cevt.fas_errored = 1'b0;
    cevt.fas_bit_errs = 3'd0;
    tick(768);
    cevt = 9'b000000010;
    tick(64512);
    cevt = '0;
    rc(5'h13, 8'h00);
    rc(5'h14, 8'h01);
    rc(5'h18, 8'h01);
    rc(5'h1A, 8'h01);
    rc(5'h1C, 8'h00);
    rc(5'h1D, 8'h01);
    rc(5'h1E, 8'h00);
    rc(5'h1F, 8'h01);
    rc(5'h16, 8'h4F);
  endtask

  task automatic frame(input int n);
    repeat (n) begin
      tick_f = 1'b1;
      tick(1);
      tick_f = 1'b0;
      tick(2);
    end
  endtask

  task automatic t_sync_loss();
    lost = 1'b1;
    frame(3);
    lost = 1'b0;
    frame(2);
    rc(5'h17, 8'h03);
    lost = 1'b1;
    tick(2);
    frame(1);
    rc(5'h17, 8'h01);
    lost = 1'b0;
  endtask

  task automatic t_jitter();
    nunder = 1'b1;
    tick(1);
    chk({6'h00, slow, fast}, 8'h02);
    tick(3);
    nunder = 1'b0;
    tick(2);
    nover = 1'b1;
    tick(1);
    chk({6'h00, slow, fast}, 8'h01);
    tick(3);
    nover = 1'b0;
    rc(5'h15, 8'h02);
  endtask

  task automatic t_alarms();
    aevt = 7'h7F;
    win = 1'b1;
    pers = 1'b1;
    tick(1);
    aevt = '0;
    win = 1'b0;
    rc(5'h1B, 8'hFE);
    rc(5'h1B, 8'h00);
    rc(5'h19, 8'h03);
    rc(5'h19, 8'h01);
  endtask

  task automatic wrap_up();
    $display("Checks made %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    tick(6);
    i_rst_n = 1'b1;
    t_reset_map();
    t_pattern_window();
    t_wide_counters();
    t_sync_loss();
    t_jitter();
    t_alarms();
    wrap_up();
  end

  // About 66000 cycles expected; cut off at 80000
  initial begin
    #8_000_000;
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
